// *** rtl/rcpc_pkg.sv ***
// Purpose: Shared constants and types for the clear/preset control block
// Assumes: 32-bit AXI4-Lite register access, four logic cells in one group
// Notes:   Offsets are byte addresses, one aligned word per register
package rcpc_pkg;

	localparam int NCELL = 4;

	// Clock and power-up timing
	localparam int CLK_PERIOD_NS  = 40;
	localparam int PWRUP_TIME_NS  = 2000;
	localparam int PWRUP_CYCLES   = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWRUP_CNT_W    = 8;

	// Register offsets
	localparam logic [3:0] OFS_CFG    = 4'h0;
	localparam logic [3:0] OFS_ENABLE = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;

	// Configuration field positions
	localparam int CFG_MODE_LSB  = 0;
	localparam int CFG_SEL_LSB   = 4;
	localparam int CFG_INV_LSB   = 8;
	localparam int CFG_IOINV_LSB = 12;
	localparam int CFG_USE_LSB   = 16;
	localparam int CFG_CHIPCLR   = 20;
	localparam int CFG_LOCALCTL  = 21;

	// Enable register field positions
	localparam int EN_BUSOE_LSB = 0;
	localparam int EN_PINOE_LSB = 4;

	// Status field positions
	localparam int ST_Q_LSB     = 0;
	localparam int ST_BUS       = 4;
	localparam int ST_CONTEND   = 5;
	localparam int ST_FLOAT     = 6;
	localparam int ST_POWERED   = 7;
	localparam int ST_PIN_LSB   = 8;

	// Reset values
	localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		RCPC_MODE_CLEAR  = 1'h0,
		RCPC_MODE_PRESET = 1'h1
	} rcpc_mode_t;

	// Per-cell configuration fields plus group-wide chip clear enable and local control
	typedef struct packed {
		logic [NCELL-1:0] mode;
		logic [NCELL-1:0] sel_b;
		logic [NCELL-1:0] in_inv;
		logic [NCELL-1:0] io_inv;
		logic [NCELL-1:0] use_clr;
		logic             chip_clr_en;
		logic             local_ctl;
	} rcpc_cfg_t;

	// Emulated bus result
	typedef struct packed {
		logic value;
		logic contend;
		logic float_bus;
	} rcpc_bus_t;

	typedef struct packed {
		logic stored;
	} rcpc_cell_st_t;

endpackage : rcpc_pkg

// *** rtl/rcpc_cell.sv ***
// Purpose: One logic-cell register with asynchronous clear and inverter pair
// Assumes: clear_n is active low and already resolved by the group logic
// Notes:   Preset mode stores the inverted value so a clear reads back high
`timescale 1ns/1ps
module rcpc_cell
	import rcpc_pkg::*;
(
	// Clock and resets
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic clear_n,
	// Cell data
	input  wire logic clk_en,
	input  wire logic d,
	// Configuration
	input  wire logic preset_mode,
	input  wire logic in_inv,
	// Result
	output logic      q
);

	rcpc_cell_st_t st;
	rcpc_cell_st_t next_st;
	logic          d_eff;

	always_comb begin
		next_st = st;
		d_eff = d ^ in_inv;
		if (clk_en) begin
			next_st.stored = d_eff ^ preset_mode;
		end
	end

	always_ff @(posedge clk_sys or posedge rst or negedge clear_n) begin
		if (rst || !clear_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.stored ^ preset_mode;

endmodule // rcpc_cell

// *** rtl/rcpc_top.sv ***
// Purpose: Clear/preset control around a group of logic-cell registers
// Assumes: AXI4-Lite slave, 32-bit data, inputs synchronous to clk_sys
// Notes:   Four cells drive an emulated shared bus and four pins
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rcpc_top
	import rcpc_pkg::*;
(
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// AXI4-Lite write address
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [3:0]       s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	// AXI4-Lite write response
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	output logic [1:0]            s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	input  wire logic [3:0]       s_axi_araddr,
	// AXI4-Lite read data
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	// Group control and chip-wide clear, active low
	input  wire logic             group_control_line_a_n,
	input  wire logic             group_control_line_b_n,
	input  wire logic             chip_wide_clear_n,
	// Inputs of the first logic cell, used as local control
	input  wire logic [1:0]       first_cell_ctl_n,
	// Logic cell data and group clock enable
	input  wire logic             cell_clk_en,
	input  wire logic [NCELL-1:0] cell_data_in,
	// Emulated bus result
	output logic                  bus_value,
	// Pins
	output logic [NCELL-1:0]      pin_out,
	output logic [NCELL-1:0]      pin_oe
);

	typedef struct packed {
		logic [31:0]            cfg;
		logic [31:0]            enable;
		logic                   aw_held;
		logic [3:0]             awaddr;
		logic                   w_held;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
		logic [PWRUP_CNT_W-1:0] pwr_cnt;
		logic                   powered;
		rcpc_bus_t              bus;
		logic [NCELL-1:0]       pin_out;
		logic [NCELL-1:0]       pin_oe;
	} rcpc_top_st_t;

	rcpc_top_st_t     st;
	rcpc_top_st_t     next_st;
	rcpc_cfg_t        cfg;
	rcpc_bus_t        bus_now;
	logic [NCELL-1:0] cell_q;
	logic [NCELL-1:0] cell_clr_n;
	logic             line_a_n;
	logic             line_b_n;
	logic             chip_clr_act;
	logic             wr_aw_ok;
	logic             wr_w_ok;
	logic [3:0]       wr_addr;
	logic [31:0]      wr_data;
	logic [3:0]       wr_strb;

	// Register picked by a bus address
	typedef enum logic [1:0] {
		RCPC_SEL_CFG    = 2'h0,
		RCPC_SEL_ENABLE = 2'h1,
		RCPC_SEL_STATUS = 2'h3,
		RCPC_SEL_NONE   = 2'h2
	} rcpc_sel_t;

	// Address decode shared by write and read
	function automatic rcpc_sel_t decode_addr(input logic [3:0] addr);
		rcpc_sel_t s;
		case (addr)
			OFS_CFG: begin
				s = RCPC_SEL_CFG;
			end
			OFS_ENABLE: begin
				s = RCPC_SEL_ENABLE;
			end
			OFS_STATUS: begin
				s = RCPC_SEL_STATUS;
			end
			default: begin
				s = RCPC_SEL_NONE;
			end
		endcase
		return s;
	endfunction

	// Live status word for the read path
	function automatic logic [31:0] status_word(input logic [NCELL-1:0] q,
		input rcpc_bus_t b, input logic pwr, input logic [NCELL-1:0] pins);
		logic [31:0] w;
		w                      = 32'h0000_0000;
		w[ST_Q_LSB +: NCELL]   = q;
		w[ST_BUS]              = b.value;
		w[ST_CONTEND]          = b.contend;
		w[ST_FLOAT]            = b.float_bus;
		w[ST_POWERED]          = pwr;
		w[ST_PIN_LSB +: NCELL] = pins;
		return w;
	endfunction

	// Byte-lane merge of a write into a register
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Resolve the emulated shared bus from enables and data
	function automatic rcpc_bus_t resolve_bus(input logic [NCELL-1:0] oe,
		input logic [NCELL-1:0] data);
		rcpc_bus_t   r;
		logic [2:0]  n;
		n = 3'h0;
		r = '0;
		for (int i = 0; i < NCELL; i++) begin
			n = n + {2'h0, oe[i]};
		end
		case (n)
			3'h0: begin
				r.value     = 1'b1;
				r.float_bus = 1'b1;
			end
			3'h1: begin
				r.value = |(oe & data);
			end
			default: begin
				r.value   = 1'b0;
				r.contend = 1'b1;
			end
		endcase
		return r;
	endfunction

	// Configuration unpacked from the register
	always_comb begin
		cfg.mode        = st.cfg[CFG_MODE_LSB  +: NCELL];
		cfg.sel_b       = st.cfg[CFG_SEL_LSB   +: NCELL];
		cfg.in_inv      = st.cfg[CFG_INV_LSB   +: NCELL];
		cfg.io_inv      = st.cfg[CFG_IOINV_LSB +: NCELL];
		cfg.use_clr     = st.cfg[CFG_USE_LSB   +: NCELL];
		cfg.chip_clr_en = st.cfg[CFG_CHIPCLR];
		cfg.local_ctl   = st.cfg[CFG_LOCALCTL];
	end

	// Group control sourcing and clear resolution
	always_comb begin
		if (cfg.local_ctl) begin
			line_a_n = first_cell_ctl_n[0];
			line_b_n = first_cell_ctl_n[1];
		end else begin
			line_a_n = group_control_line_a_n;
			line_b_n = group_control_line_b_n;
		end
		chip_clr_act = cfg.chip_clr_en && !chip_wide_clear_n;
		for (int i = 0; i < NCELL; i++) begin
			cell_clr_n[i] = 1'b1;
			if (cfg.use_clr[i]) begin
				cell_clr_n[i] = cfg.sel_b[i] ? line_b_n : line_a_n;
			end
			if (chip_clr_act) begin
				cell_clr_n[i] = 1'b0;
			end
		end
	end

	// Preset cell reads high on clear
	for (genvar g = 0; g < NCELL; g++) begin : g_cell
		rcpc_cell rcpc_cell_i (
			.clk_sys     (clk_sys),
			.rst         (rst),
			.clear_n     (cell_clr_n[g]),
			.clk_en      (cell_clk_en),
			.d           (cell_data_in[g]),
			.preset_mode (cfg.mode[g] == RCPC_MODE_PRESET),
			.in_inv      (cfg.in_inv[g]),
			.q           (cell_q[g])
		);
	end

	assign bus_now = resolve_bus(st.enable[EN_BUSOE_LSB +: NCELL], cell_q);

	// Write channel acceptance, either order
	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready  = !st.w_held && !st.bvalid;
	assign wr_aw_ok      = st.aw_held || (s_axi_awvalid && s_axi_awready);
	assign wr_w_ok       = st.w_held || (s_axi_wvalid && s_axi_wready);
	assign wr_addr       = st.aw_held ? st.awaddr : s_axi_awaddr;
	assign wr_data       = st.w_held ? st.wdata : s_axi_wdata;
	assign wr_strb       = st.w_held ? st.wstrb : s_axi_wstrb;
	assign s_axi_arready = !st.rvalid;

	always_comb begin
		next_st = st;
		// Write address and data capture
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_held = 1'b1;
			next_st.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_held = 1'b1;
			next_st.wdata  = s_axi_wdata;
			next_st.wstrb  = s_axi_wstrb;
		end
		// Register write once both halves are in
		if (wr_aw_ok && wr_w_ok && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = RESP_OKAY;
			case (decode_addr(wr_addr))
				RCPC_SEL_CFG: begin
					next_st.cfg = merge_strb(st.cfg, wr_data, wr_strb);
				end
				RCPC_SEL_ENABLE: begin
					next_st.enable = merge_strb(st.enable, wr_data, wr_strb);
				end
				RCPC_SEL_STATUS: begin
					next_st.bresp = RESP_SLVERR;
				end
				default: begin
					next_st.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// Read path
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = RESP_OKAY;
			next_st.rdata  = 32'h0000_0000;
			case (decode_addr(s_axi_araddr))
				RCPC_SEL_CFG: begin
					next_st.rdata = st.cfg;
				end
				RCPC_SEL_ENABLE: begin
					next_st.rdata = st.enable;
				end
				RCPC_SEL_STATUS: begin
					next_st.rdata = status_word(cell_q, st.bus, st.powered, st.pin_out);
				end
				default: begin
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (!st.powered) begin
			if (st.pwr_cnt == PWRUP_CNT_W'(PWRUP_CYCLES - 1)) begin
				next_st.powered = 1'b1;
			end else begin
				next_st.pwr_cnt = st.pwr_cnt + PWRUP_CNT_W'(1);
			end
		end
		// Bus and pin outputs
		next_st.bus = bus_now;
		next_st.pin_out = cell_q ^ cfg.io_inv;
		next_st.pin_oe = st.powered ? st.enable[EN_PINOE_LSB +: NCELL] : '0;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st        <= '0;
			st.cfg    <= CFG_RESET;
			st.enable <= ENABLE_RESET;
			st.bus    <= '{value: 1'b1, contend: 1'b0, float_bus: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp  = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata  = st.rdata;
	assign s_axi_rresp  = st.rresp;
	assign bus_value    = st.bus.value;
	assign pin_out      = st.pin_out;
	assign pin_oe       = st.pin_oe;

endmodule // rcpc_top

// *** tb/rcpc_top_props.sv ***
// Purpose: Concurrent checks on the clear/preset control block ports
// Assumes: Single clock domain, reset active high
// Notes:   Bound to the top module from the bench
`timescale 1ns/1ps
module rcpc_top_props
	import rcpc_pkg::*;
(
	// Clock and reset
	input wire logic             clk_sys,
	input wire logic             rst,
	// Register bus handshakes
	input wire logic             s_axi_awready,
	input wire logic             s_axi_wready,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	// Pins
	input wire logic [NCELL-1:0] pin_oe
);
	logic [7:0] up_cnt;

	// Cycles since reset release
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			up_cnt <= 8'h00;
		end else if (up_cnt != 8'hff) begin
			up_cnt <= up_cnt + 8'h01;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_PWRUP_QUIET: assert property (up_cnt < PWRUP_CYCLES |-> pin_oe == '0)
		else $error("pins driven during power-up");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not retired");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped early");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not retired");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
endmodule // rcpc_top_props

// *** tb/rcpc_top_test.sv ***
// Purpose: Self-checking bench for the clear/preset control block
// Assumes: Design reached only through its ports
// Notes:   Checker is bound below the module
`timescale 1ns/1ps
module rcpc_top_test
	import rcpc_pkg::*;
();
	logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, group_control_line_a_n, group_control_line_b_n;
	logic        chip_wide_clear_n, cell_clk_en, bus_value;
	logic [1:0]  s_axi_bresp, s_axi_rresp, first_cell_ctl_n;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, cell_data_in, pin_out, pin_oe;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	int          fails, compares;

	rcpc_top rcpc_top_i (
		.clk_sys                (clk_sys),
		.rst                    (rst),
		.s_axi_awvalid          (s_axi_awvalid),
		.s_axi_awready          (s_axi_awready),
		.s_axi_awaddr           (s_axi_awaddr),
		.s_axi_wvalid           (s_axi_wvalid),
		.s_axi_wready           (s_axi_wready),
		.s_axi_wdata            (s_axi_wdata),
		.s_axi_wstrb            (s_axi_wstrb),
		.s_axi_bvalid           (s_axi_bvalid),
		.s_axi_bready           (s_axi_bready),
		.s_axi_bresp            (s_axi_bresp),
		.s_axi_arvalid          (s_axi_arvalid),
		.s_axi_arready          (s_axi_arready),
		.s_axi_araddr           (s_axi_araddr),
		.s_axi_rvalid           (s_axi_rvalid),
		.s_axi_rready           (s_axi_rready),
		.s_axi_rdata            (s_axi_rdata),
		.s_axi_rresp            (s_axi_rresp),
		.group_control_line_a_n (group_control_line_a_n),
		.group_control_line_b_n (group_control_line_b_n),
		.chip_wide_clear_n      (chip_wide_clear_n),
		.first_cell_ctl_n       (first_cell_ctl_n),
		.cell_clk_en            (cell_clk_en),
		.cell_data_in           (cell_data_in),
		.bus_value              (bus_value),
		.pin_out                (pin_out),
		.pin_oe                 (pin_oe)
	);

	always #20 clk_sys = ~clk_sys;

	task automatic chk(input bit ok, input string msg);
		compares++;
		if (!ok) begin
			fails++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r,
		input int lag = 0);
		bit ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= (lag == 0);
		while (!(ta && tw)) begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (lag > 0) begin
			repeat (lag) @(posedge clk_sys);
			chk(s_axi_bvalid === 1'b1, "write response not held");
			s_axi_bready <= 1'b1;
		end
		do @(posedge clk_sys); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp === r, "write response");
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] r, input int lag = 0);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= (lag == 0);
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		if (lag > 0) begin
			repeat (lag) @(posedge clk_sys);
			chk(s_axi_rvalid === 1'b1, "read data not held");
			s_axi_rready <= 1'b1;
		end
		do @(posedge clk_sys); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk((s_axi_rdata & m) === (e & m) && s_axi_rresp === r, "read data");
		@(posedge clk_sys);
	endtask

	task automatic stq(input logic [3:0] e);
		rd(OFS_STATUS, {28'h0, e}, 32'hf, RESP_OKAY);
	endtask

	task automatic ld(input logic [3:0] d);
		cell_data_in <= d;
		cell_clk_en <= 1'b1;
		@(posedge clk_sys);
		cell_clk_en <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic bus(input logic [3:0] en, input logic e);
		wr(OFS_ENABLE, {24'h0, 4'hf, en}, RESP_OKAY);
		rd(OFS_STATUS, {25'h0, (en == 4'h0), ($countones(en) > 1), e, 4'h0}, 32'h70, RESP_OKAY);
		chk(bus_value === e, "bus value");
	endtask

	task automatic t_regs();
		rd(OFS_CFG, CFG_RESET, 32'hffffffff, RESP_OKAY);
		rd(OFS_ENABLE, ENABLE_RESET, 32'hffffffff, RESP_OKAY);
		rd(4'hc, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr(OFS_STATUS, 32'hff, RESP_SLVERR);
		s_axi_wstrb <= 4'h6;
		wr(OFS_ENABLE, 32'hffff_ffff, RESP_OKAY, 2);
		s_axi_wstrb <= 4'hf;
		rd(OFS_ENABLE, 32'h00ff_ff00, 32'hffffffff, RESP_OKAY, 2);
		wr(OFS_ENABLE, 32'hf0, RESP_OKAY);
		chk(pin_oe === 4'h0, "pins driven early");
		repeat (PWRUP_CYCLES) @(posedge clk_sys);
		rd(OFS_STATUS, 32'h80, 32'h80, RESP_OKAY);
		chk(pin_oe === 4'hf, "pins not driven");
	endtask

	task automatic t_bus();
		ld(4'h6);
		bus(4'h0, 1'b1);
		bus(4'h1, 1'b0);
		bus(4'h2, 1'b1);
		bus(4'h6, 1'b0);
	endtask

	task automatic t_clear();
		ld(4'hf);
		wr(OFS_CFG, 32'h000f_00a0, RESP_OKAY);
		group_control_line_a_n <= 1'b0;
		ld(4'hf);
		stq(4'ha);
		group_control_line_a_n <= 1'b1;
		group_control_line_b_n <= 1'b0;
		ld(4'hf);
		stq(4'h5);
		group_control_line_b_n <= 1'b1;
		wr(OFS_CFG, 32'h0, RESP_OKAY);
		ld(4'hf);
		group_control_line_a_n <= 1'b0;
		stq(4'hf);
		group_control_line_a_n <= 1'b1;
		wr(OFS_CFG, 32'h002f_0000, RESP_OKAY);
		first_cell_ctl_n <= 2'b10;
		stq(4'h0);
		first_cell_ctl_n <= 2'b11;
	endtask

	task automatic t_preset();
		wr(OFS_CFG, 32'h0010_000f, RESP_OKAY);
		ld(4'h0);
		stq(4'h0);
		chip_wide_clear_n <= 1'b0;
		cell_clk_en <= 1'b1;
		@(posedge clk_sys);
		stq(4'hf);
		chk(pin_out === 4'hf, "clock overrode chip clear");
		chip_wide_clear_n <= 1'b1;
		cell_clk_en <= 1'b0;
		wr(OFS_CFG, 32'h0010_0003, RESP_OKAY);
		ld(4'hf);
		chip_wide_clear_n <= 1'b0;
		stq(4'h3);
		chip_wide_clear_n <= 1'b1;
		wr(OFS_CFG, 32'h0000_0003, RESP_OKAY);
		ld(4'hf);
		chip_wide_clear_n <= 1'b0;
		stq(4'hf);
		chip_wide_clear_n <= 1'b1;
	endtask

	task automatic t_inv();
		wr(OFS_CFG, 32'h0000_5f00, RESP_OKAY);
		ld(4'h5);
		rd(OFS_STATUS, 32'hf0a, 32'hf0f, RESP_OKAY);
		chk(pin_out === 4'hf, "pin inversion");
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		conclude();
	end

	initial begin
		clk_sys = 1'b0;
		rst <= 1'b1;
		s_axi_awvalid <= 1'b0;
		s_axi_awaddr <= 4'h0;
		s_axi_wvalid <= 1'b0;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'hf;
		s_axi_bready <= 1'b0;
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= 4'h0;
		s_axi_rready <= 1'b0;
		group_control_line_a_n <= 1'b1;
		group_control_line_b_n <= 1'b1;
		chip_wide_clear_n <= 1'b1;
		first_cell_ctl_n <= 2'b11;
		cell_clk_en <= 1'b0;
		cell_data_in <= 4'h0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		t_bus();
		t_clear();
		t_preset();
		t_inv();
		conclude();
	end
endmodule // rcpc_top_test

bind rcpc_top rcpc_top_props rcpc_top_props_i (
	.clk_sys       (clk_sys),
	.rst           (rst),
	.s_axi_awready (s_axi_awready),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.pin_oe        (pin_oe)
);
